// ### rtcp_pkg.sv
// rtcp_pkg: register map, field layout, reset values and timing constants of the counter block
// Operation
// - count prescaled ticks in 16 bits, compare against period and compare values
// - first tick after count equals compare raises compare request and event
// - first tick after count equals period raises overflow request, event, clears count
// - reference clock passes a 16-bit prescaler, division picked by tick divider field
// - clock source select picks crystal, external clock, low speed oscillator or it/32
// - error correction skips or adds prescaler counts, 1 ppm steps, up to 127 ppm
// - periodic timer interrupt every 4..32768 periods, level events 64..8192
// - periodic timer works whether or not the counter is enabled
// - counter enable bit in control register starts and stops the counter
// - periodic timer enable bit in periodic control register starts and stops it
// - separate compare and overflow interrupt enables gate each request
// - both functions take timing from one shared prescaler counter
// - one clock source selection serves both functions
// - counter keeps running in sleep and its interrupts can wake the device
// - shared prescaler stops when both enables are zero, runs if either is one
// - periodic output follows the selected prescaler bit, toggling every half period while enabled
package rtcp_pkg;
  // byte addresses of the word registers
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h08;
  localparam logic [7:0] ADDR_INT_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_PERIOD = 8'h14;
  localparam logic [7:0] ADDR_COMPARE = 8'h18;
  localparam logic [7:0] ADDR_CLK_SEL = 8'h1c;
  localparam logic [7:0] ADDR_CALIB = 8'h20;
  localparam logic [7:0] ADDR_PIT_CTRL = 8'h24;
  localparam logic [7:0] ADDR_PIT_STATUS = 8'h28;
  localparam logic [7:0] ADDR_PIT_INT_CTRL = 8'h2c;
  localparam logic [7:0] ADDR_PIT_INT_FLAGS = 8'h30;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DIV_LSB = 3;
  localparam int CTRL_CORR_BIT = 7;
  localparam int INT_OVF_BIT = 0;
  localparam int INT_CMP_BIT = 1;
  localparam int BUSY_CTRL_BIT = 0;
  localparam int BUSY_CNT_BIT = 1;
  localparam int BUSY_PER_BIT = 2;
  localparam int BUSY_CMP_BIT = 3;
  localparam int CALIB_SIGN_BIT = 7;
  localparam int PIT_EN_BIT = 0;
  localparam int PIT_PER_LSB = 3;

  // widths and reset values
  localparam int CNT_W = 16;
  localparam int PRESC_W = 16;
  localparam int CORR_W = 20;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [15:0] COMPARE_RST = 16'h0000;
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [3:0] PIT_PER_OFF = 4'h0;
  localparam logic [3:0] PIT_PER_MAX = 4'he;
  localparam int PIT_EV_LSB = 5;
  localparam int PIT_EV_N = 8;
  localparam logic [4:0] OSC_DIV_LAST = 5'h1f;

  // timing figures
  localparam int SYS_CLK_HZ = 20000000;
  localparam int REF_CLK_HZ = 32768;
  localparam int BUS_TO_REF_MIN_RATIO = 4;
  localparam int CORR_WINDOW_CYCLES = 1000000;

  typedef enum logic [1:0] {
    RTCP_SRC_XTAL,
    RTCP_SRC_EXT,
    RTCP_SRC_OSC,
    RTCP_SRC_OSC_DIV32
  } rtcp_src_t;
endpackage

// ### rtcp_sync.sv
// rtcp_sync: two-flop synchroniser with rising edge pulse per lane
`timescale 1ns/1ps
module rtcp_sync #(
  parameter int WIDTH = 3
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] rise_pulse
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] last_q;

  // edge detect looks only at the second and third stages, never the metastable first one
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise_pulse = sync_q & ~last_q;
endmodule

// ### rtcp_top.sv
// rtcp_top: real-time counter and periodic timer on one shared prescaler, Avalon-MM slave
`timescale 1ns/1ps
module rtcp_top #(
  parameter int CORR_WINDOW = rtcp_pkg::CORR_WINDOW_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic xtal_clk_pin,
  input wire logic ext_clk_pin,
  input wire logic osc_clk_pin,
  output logic ovf_irq,
  output logic cmp_irq,
  output logic pit_irq,
  output logic wake_req,
  output logic ovf_event,
  output logic cmp_event,
  output logic pit_wave,
  output logic [7:0] pit_event
);
  // byte-lane merge, used by the count write and the flag clears
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // one-hot mask of the single prescaler bit picked by a 4-bit index
  function automatic logic [15:0] bit_mask(input logic [3:0] idx);
    return 16'h0001 << idx;
  endfunction

  // bus handshake state
  logic ack_q;
  logic [31:0] rdata_q;
  logic req;
  logic wr_go;

  // register state
  logic cnt_en_q;
  logic corr_en_q;
  logic [3:0] tick_div_q;
  logic ovf_ie_q;
  logic cmp_ie_q;
  logic ovf_flag_q;
  logic cmp_flag_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] period_q;
  logic [15:0] compare_q;
  logic [1:0] clk_sel_q;
  logic calib_slow_q;
  logic [6:0] calib_err_q;
  logic pit_en_q;
  logic [3:0] pit_per_q;
  logic pit_ie_q;
  logic pit_flag_q;
  logic [3:0] busy_q;
  logic pit_busy_q;

  // clock source and prescaler state
  logic [2:0] pin_rise;
  logic [4:0] osc_div_q;
  logic osc_div_tick;
  logic ref_tick;
  logic [19:0] corr_acc_q;
  logic [19:0] corr_sum;
  logic corr_fire;
  logic [1:0] presc_step;
  logic [15:0] presc_q;
  logic [15:0] presc_d;
  logic presc_run;
  logic cnt_tick;
  logic pit_rise;
  logic pit_bit_now;
  logic pit_bit_nxt;
  logic ovf_hit;
  logic cmp_hit;
  logic ovf_ev_q;
  logic cmp_ev_q;
  logic pit_wave_q;
  logic [7:0] pit_event_q;

  // address decode
  logic hit_ctrl, hit_stat, hit_ictl, hit_iflg, hit_cnt, hit_per, hit_cmp;
  logic hit_csel, hit_cal, hit_pctl, hit_pstat, hit_pictl, hit_piflg;
  logic [31:0] wmerge;
  logic [31:0] rmux;

  // reference pins cross into the bus clock domain before any use
  rtcp_sync #(.WIDTH(3)) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in({osc_clk_pin, ext_clk_pin, xtal_clk_pin}),
    .rise_pulse(pin_rise)
  );

  // bus: one wait state, read data registered on the first edge of a request
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_go = avs_write & ack_q;
  assign avs_readdata = rdata_q;

  assign hit_ctrl = avs_address == rtcp_pkg::ADDR_CTRL_A;
  assign hit_stat = avs_address == rtcp_pkg::ADDR_STATUS;
  assign hit_ictl = avs_address == rtcp_pkg::ADDR_INT_CTRL;
  assign hit_iflg = avs_address == rtcp_pkg::ADDR_INT_FLAGS;
  assign hit_cnt = avs_address == rtcp_pkg::ADDR_COUNT;
  assign hit_per = avs_address == rtcp_pkg::ADDR_PERIOD;
  assign hit_cmp = avs_address == rtcp_pkg::ADDR_COMPARE;
  assign hit_csel = avs_address == rtcp_pkg::ADDR_CLK_SEL;
  assign hit_cal = avs_address == rtcp_pkg::ADDR_CALIB;
  assign hit_pctl = avs_address == rtcp_pkg::ADDR_PIT_CTRL;
  assign hit_pstat = avs_address == rtcp_pkg::ADDR_PIT_STATUS;
  assign hit_pictl = avs_address == rtcp_pkg::ADDR_PIT_INT_CTRL;
  assign hit_piflg = avs_address == rtcp_pkg::ADDR_PIT_INT_FLAGS;

  // write data merged against zero; fields below pick their own bits
  assign wmerge = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);

  // read mux; unmapped addresses read as zero
  assign rmux =
    hit_ctrl ? {24'h0, corr_en_q, tick_div_q, 2'b00, cnt_en_q} :
    hit_stat ? {28'h0, busy_q} :
    hit_ictl ? {30'h0, cmp_ie_q, ovf_ie_q} :
    hit_iflg ? {30'h0, cmp_flag_q, ovf_flag_q} :
    hit_cnt ? {16'h0, count_q} :
    hit_per ? {16'h0, period_q} :
    hit_cmp ? {16'h0, compare_q} :
    hit_csel ? {30'h0, clk_sel_q} :
    hit_cal ? {24'h0, calib_slow_q, calib_err_q} :
    hit_pctl ? {25'h0, pit_per_q, 2'b00, pit_en_q} :
    hit_pstat ? {31'h0, pit_busy_q} :
    hit_pictl ? {31'h0, pit_ie_q} :
    hit_piflg ? {31'h0, pit_flag_q} : 32'h0000_0000;

  // bus handshake registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read & ~ack_q) begin
        rdata_q <= rmux;
      end
    end
  end

  // source selection, osc/32 made by counting oscillator edges
  assign osc_div_tick = pin_rise[2] & (osc_div_q == rtcp_pkg::OSC_DIV_LAST);
  always_comb begin
    unique case (rtcp_pkg::rtcp_src_t'(clk_sel_q))
      rtcp_pkg::RTCP_SRC_XTAL: ref_tick = pin_rise[0];
      rtcp_pkg::RTCP_SRC_EXT: ref_tick = pin_rise[1];
      rtcp_pkg::RTCP_SRC_OSC: ref_tick = pin_rise[2];
      rtcp_pkg::RTCP_SRC_OSC_DIV32: ref_tick = osc_div_tick;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_div_q <= 5'h00;
    end else if (pin_rise[2]) begin
      osc_div_q <= osc_div_q + 5'h01;
    end
  end

  // error correction: accumulate ppm per reference tick, act once per million
  assign corr_sum = corr_acc_q + {13'h0, calib_err_q};
  assign corr_fire = corr_en_q & ref_tick & (corr_sum >= CORR_WINDOW[19:0]);
  // a fire adds a count (step 2) to speed up, or drops one (step 0) to slow down
  assign presc_step = ~ref_tick ? 2'd0 :
                      ~corr_fire ? 2'd1 :
                      calib_slow_q ? 2'd0 : 2'd2;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      corr_acc_q <= 20'h00000;
    end else if (!corr_en_q) begin
      corr_acc_q <= 20'h00000;
    end else if (ref_tick) begin
      corr_acc_q <= corr_fire ? corr_sum - CORR_WINDOW[19:0] : corr_sum;
    end
  end

  // shared prescaler; halted and cleared when both functions are off
  assign presc_run = cnt_en_q | pit_en_q;
  assign presc_d = presc_q + {14'h0, presc_step};
  // a tick is a carry into the selected bit, so a skipped count cannot hide one
  assign cnt_tick = (presc_step != 2'd0) &
                    ((tick_div_q == 4'h0) ||
                     ((presc_d & bit_mask(tick_div_q)) != (presc_q & bit_mask(tick_div_q))));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_q <= 16'h0000;
    end else if (!presc_run) begin
      presc_q <= 16'h0000;
    end else begin
      presc_q <= presc_d;
    end
  end

  // counter compare; hits act on the tick following equality
  assign ovf_hit = cnt_en_q & cnt_tick & (count_q == period_q);
  assign cmp_hit = cnt_en_q & cnt_tick & (count_q == compare_q);
  assign count_d = ovf_hit ? 16'h0000 : count_q + 16'h0001;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 16'h0000;
    end else if (wr_go & hit_cnt) begin
      count_q <= wmerge[15:0] | (count_q & ~{{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}});
    end else if (cnt_en_q & cnt_tick) begin
      count_q <= count_d;
    end
  end

  // periodic timer follows prescaler bit pit_per; rising edge is one full period
  assign pit_bit_now = (presc_q & bit_mask(pit_per_q)) != 16'h0000;
  assign pit_bit_nxt = (presc_d & bit_mask(pit_per_q)) != 16'h0000;
  assign pit_rise = pit_en_q & (pit_per_q != rtcp_pkg::PIT_PER_OFF) &
                    (pit_per_q <= rtcp_pkg::PIT_PER_MAX) & ~pit_bit_now & pit_bit_nxt;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pit_wave_q <= 1'b0;
      pit_event_q <= 8'h00;
    end else begin
      pit_wave_q <= pit_en_q & (pit_per_q != rtcp_pkg::PIT_PER_OFF) & pit_bit_nxt;
      pit_event_q <= pit_en_q ? presc_d[rtcp_pkg::PIT_EV_LSB +: rtcp_pkg::PIT_EV_N] : 8'h00;
    end
  end

  // overflow and compare event pulses
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ovf_ev_q <= 1'b0;
      cmp_ev_q <= 1'b0;
    end else begin
      ovf_ev_q <= ovf_hit;
      cmp_ev_q <= cmp_hit;
    end
  end

  // control registers written by software
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_en_q <= 1'b0;
      corr_en_q <= 1'b0;
      tick_div_q <= rtcp_pkg::DIV_RST;
      ovf_ie_q <= 1'b0;
      cmp_ie_q <= 1'b0;
      period_q <= rtcp_pkg::PERIOD_RST;
      compare_q <= rtcp_pkg::COMPARE_RST;
      clk_sel_q <= 2'b00;
      calib_slow_q <= 1'b0;
      calib_err_q <= 7'h00;
      pit_en_q <= 1'b0;
      pit_per_q <= rtcp_pkg::PIT_PER_OFF;
      pit_ie_q <= 1'b0;
    end else if (wr_go & avs_byteenable[0]) begin
      if (hit_ctrl) begin
        cnt_en_q <= avs_writedata[rtcp_pkg::CTRL_EN_BIT];
        tick_div_q <= avs_writedata[rtcp_pkg::CTRL_DIV_LSB +: 4];
        corr_en_q <= avs_writedata[rtcp_pkg::CTRL_CORR_BIT];
      end
      if (hit_ictl) begin
        ovf_ie_q <= avs_writedata[rtcp_pkg::INT_OVF_BIT];
        cmp_ie_q <= avs_writedata[rtcp_pkg::INT_CMP_BIT];
      end
      if (hit_per) begin
        period_q[7:0] <= avs_writedata[7:0];
      end
      if (hit_cmp) begin
        compare_q[7:0] <= avs_writedata[7:0];
      end
      if (hit_csel) begin
        clk_sel_q <= avs_writedata[1:0];
      end
      if (hit_cal) begin
        calib_slow_q <= avs_writedata[rtcp_pkg::CALIB_SIGN_BIT];
        calib_err_q <= avs_writedata[6:0];
      end
      if (hit_pctl) begin
        pit_en_q <= avs_writedata[rtcp_pkg::PIT_EN_BIT];
        pit_per_q <= avs_writedata[rtcp_pkg::PIT_PER_LSB +: 4];
      end
      if (hit_pictl) begin
        pit_ie_q <= avs_writedata[0];
      end
    end else if (wr_go & avs_byteenable[1]) begin
      if (hit_per) begin
        period_q[15:8] <= avs_writedata[15:8];
      end
      if (hit_cmp) begin
        compare_q[15:8] <= avs_writedata[15:8];
      end
    end
  end

  // sticky flags, write one to clear; a hit in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ovf_flag_q <= 1'b0;
      cmp_flag_q <= 1'b0;
      pit_flag_q <= 1'b0;
    end else begin
      ovf_flag_q <= ovf_hit |
        (ovf_flag_q & ~(wr_go & hit_iflg & wmerge[rtcp_pkg::INT_OVF_BIT]));
      cmp_flag_q <= cmp_hit |
        (cmp_flag_q & ~(wr_go & hit_iflg & wmerge[rtcp_pkg::INT_CMP_BIT]));
      pit_flag_q <= pit_rise | (pit_flag_q & ~(wr_go & hit_piflg & wmerge[0]));
    end
  end

  // busy bits: a write stands busy until the next reference tick takes it over
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 4'h0;
      pit_busy_q <= 1'b0;
    end else begin
      busy_q[rtcp_pkg::BUSY_CTRL_BIT] <= (wr_go & hit_ctrl) |
        (busy_q[rtcp_pkg::BUSY_CTRL_BIT] & ~ref_tick);
      busy_q[rtcp_pkg::BUSY_CNT_BIT] <= (wr_go & hit_cnt) |
        (busy_q[rtcp_pkg::BUSY_CNT_BIT] & ~ref_tick);
      busy_q[rtcp_pkg::BUSY_PER_BIT] <= (wr_go & hit_per) |
        (busy_q[rtcp_pkg::BUSY_PER_BIT] & ~ref_tick);
      busy_q[rtcp_pkg::BUSY_CMP_BIT] <= (wr_go & hit_cmp) |
        (busy_q[rtcp_pkg::BUSY_CMP_BIT] & ~ref_tick);
      pit_busy_q <= (wr_go & hit_pctl) | (pit_busy_q & ~ref_tick);
    end
  end

  // requests gated by their enables; any of them wakes the device from sleep
  assign ovf_irq = ovf_flag_q & ovf_ie_q;
  assign cmp_irq = cmp_flag_q & cmp_ie_q;
  assign pit_irq = pit_flag_q & pit_ie_q;
  assign wake_req = ovf_irq | cmp_irq | pit_irq;
  assign ovf_event = ovf_ev_q;
  assign cmp_event = cmp_ev_q;
  assign pit_wave = pit_wave_q;
  assign pit_event = pit_event_q;
endmodule

// ### rtcp_top_properties.sv
// rtcp_top_properties: concurrent checks on the counter block ports
`timescale 1ns/1ps
module rtcp_top_properties (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic ovf_irq,
  input wire logic cmp_irq,
  input wire logic pit_irq,
  input wire logic wake_req,
  input wire logic ovf_event,
  input wire logic cmp_event,
  input wire logic [7:0] pit_event
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // any pending request must be able to wake the device
  wake_or_a: assert property (wake_req == (ovf_irq | cmp_irq | pit_irq))
    else $error("wake request differs from irq or");
  // ticks are at least four bus cycles apart, so events never bunch up
  ovf_gap_a: assert property (ovf_event |=> (!ovf_event)[*3])
    else $error("overflow event longer than one cycle");
  cmp_gap_a: assert property (cmp_event |=> (!cmp_event)[*3])
    else $error("compare event longer than one cycle");
  // exactly one wait state for every access
  bus_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1
    !avs_waitrequest)
    else $error("access not answered after one wait state");
  idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  // event taps are bits of one binary prescaler: a bit rises only on carry
  // taps jump when the timer is switched on with the counter already running, so skip that
  carry_low_a: assert property ($rose(pit_event[1]) && $past(pit_event) != 8'h00 |->
    $fell(pit_event[0]))
    else $error("event tap 128 rose without carry");
  carry_mid_a: assert property ($rose(pit_event[4]) && $past(pit_event) != 8'h00 |->
    $fell(pit_event[3]))
    else $error("event tap 1024 rose without carry");
  carry_high_a: assert property ($rose(pit_event[7]) && $past(pit_event) != 8'h00 |->
    $fell(pit_event[6]))
    else $error("event tap 8192 rose without carry");
endmodule

bind rtcp_top rtcp_top_properties i_props (
  .sys_clk(sys_clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .ovf_irq(ovf_irq), .cmp_irq(cmp_irq),
  .pit_irq(pit_irq), .wake_req(wake_req), .ovf_event(ovf_event),
  .cmp_event(cmp_event), .pit_event(pit_event)
);

// ### rtcp_ref_clk.sv
// rtcp_ref_clk: free running crystal, external and low speed oscillator sources
`timescale 1ns/1ps
module rtcp_ref_clk #(
  parameter int XTAL_HALF = 500,
  parameter int EXT_HALF = 650,
  parameter int OSC_HALF = 350
) (
  output logic xtal_clk_pin,
  output logic ext_clk_pin,
  output logic osc_clk_pin
);
  // oscillators never stop; all well below a quarter of the bus clock
  initial begin
    xtal_clk_pin = 1'b0;
    #7;
    forever #(XTAL_HALF) xtal_clk_pin = ~xtal_clk_pin;
  end
  initial begin
    ext_clk_pin = 1'b0;
    #11;
    forever #(EXT_HALF) ext_clk_pin = ~ext_clk_pin;
  end
  initial begin
    osc_clk_pin = 1'b0;
    #3;
    forever #(OSC_HALF) osc_clk_pin = ~osc_clk_pin;
  end
endmodule

// ### tb_rtc_counter_with_periodic_timer.sv
// tb_rtc_counter_with_periodic_timer: register level tests of counter and periodic timer
`timescale 1ns/1ps
module tb_rtc_counter_with_periodic_timer;
  logic sys_clk, reset_n, avs_read, avs_write, xtal, ext, osc;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, ovf_irq, cmp_irq, pit_irq, wake_req, ovf_event, cmp_event, pit_wave;
  logic [7:0] pit_event;
  int err_count, samples_checked, cyc, t0, t1, t2;
  int srcs[5] = '{0, 0, 1, 2, 3};
  int divs[5] = '{0, 2, 0, 0, 0};
  int tps[5] = '{20, 20, 26, 14, 448}; // sys cycles per reference tick

  rtcp_top #(.CORR_WINDOW(64)) i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .xtal_clk_pin(xtal), .ext_clk_pin(ext),
    .osc_clk_pin(osc), .ovf_irq(ovf_irq), .cmp_irq(cmp_irq), .pit_irq(pit_irq),
    .wake_req(wake_req), .ovf_event(ovf_event), .cmp_event(cmp_event),
    .pit_wave(pit_wave), .pit_event(pit_event)
  );
  rtcp_ref_clk i_ref (.xtal_clk_pin(xtal), .ext_clk_pin(ext), .osc_clk_pin(osc));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // cycle stamp used to measure spacing of outputs
  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic end_of_test;
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask

  // one avalon access; the request stands until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] r);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 100) chk_word("waitrequest", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    bus(1'b1, a, d, be, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, 4'hf, r);
    chk_word("readdata", e, r & m);
  endtask

  // software waits until both synchronisers are idle before touching setup
  task automatic busy_wait;
    int n;
    n = 0;
    do begin
      bus(1'b0, rtcp_pkg::ADDR_STATUS, 32'h0, 4'hf, q);
      bus(1'b0, rtcp_pkg::ADDR_PIT_STATUS, 32'h0, 4'hf, t0);
      n++;
    end while ((q[3:0] | t0[0]) !== 1'b0 && n < 200);
    chk_word("busy", 32'h0, {28'h0, q[3:0]} | t0[0]);
  endtask

  function automatic logic sel(input int id);
    case (id)
      0: sel = ovf_event;
      1: sel = cmp_event;
      2: sel = pit_wave;
      default: sel = pit_event[0];
    endcase
  endfunction

  // cycle stamp of the next rising edge of a watched output
  task automatic rise(input int id, output int t);
    logic p;
    int n;
    p = sel(id);
    for (n = 0; n < 8000; n++) begin
      @(posedge sys_clk);
      #1;
      if (sel(id) === 1'b1 && p !== 1'b1) break;
      p = sel(id);
    end
    t = cyc;
    if (n >= 8000) chk_word("edge wait", 32'h0, 32'h1);
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    end_of_test;
  end

  initial begin
    {reset_n, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    err_count = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    busy_wait;
    rd_chk(rtcp_pkg::ADDR_PERIOD, 32'h0000ffff, 32'hffffffff);
    rd_chk(rtcp_pkg::ADDR_COMPARE, 32'h0, 32'hffffffff);
    rd_chk(rtcp_pkg::ADDR_CTRL_A, 32'h0, 32'hffffffff);
    wr(8'h3c, 32'hffffffff, 4'hf);
    rd_chk(8'h3c, 32'h0, 32'hffffffff);
    wr(rtcp_pkg::ADDR_COUNT, 32'h1234, 4'h3);
    repeat (100) @(posedge sys_clk);
    rd_chk(rtcp_pkg::ADDR_COUNT, 32'h1234, 32'hffff);
    // period 3 and compare 1, each written a byte lane at a time
    wr(rtcp_pkg::ADDR_PERIOD, 32'h3, 4'h1);
    wr(rtcp_pkg::ADDR_PERIOD, 32'h0, 4'h2);
    wr(rtcp_pkg::ADDR_COMPARE, 32'h1, 4'h1);
    wr(rtcp_pkg::ADDR_COMPARE, 32'h0, 4'h2);
    wr(rtcp_pkg::ADDR_INT_CTRL, 32'h3, 4'h1);
    for (int i = 0; i < 5; i++) begin
      wr(rtcp_pkg::ADDR_CTRL_A, 32'h0, 4'h1);
      busy_wait;
      wr(rtcp_pkg::ADDR_CLK_SEL, 32'(srcs[i]), 4'h1);
      wr(rtcp_pkg::ADDR_COUNT, 32'h0, 4'h3);
      wr(rtcp_pkg::ADDR_CTRL_A, (32'(divs[i]) << rtcp_pkg::CTRL_DIV_LSB) | 32'h1, 4'h1);
      rise(1, t0);
      rise(0, t1);
      rise(0, t2);
      chk_word("cmp to ovf", 32'((2 * tps[i]) << divs[i]), 32'(t1 - t0));
      chk_word("ovf period", 32'((4 * tps[i]) << divs[i]), 32'(t2 - t1));
      chk_bit("ovf_irq", 1'b1, ovf_irq);
      chk_bit("cmp_irq", 1'b1, cmp_irq);
      chk_bit("wake_req", 1'b1, wake_req);
    end
    wr(rtcp_pkg::ADDR_CTRL_A, 32'h0, 4'h1);
    wr(rtcp_pkg::ADDR_INT_FLAGS, 32'h3, 4'h1);
    rd_chk(rtcp_pkg::ADDR_INT_FLAGS, 32'h0, 32'h3);
    chk_bit("ovf_irq", 1'b0, ovf_irq);
    // masked: flag still sets but no request leaves the block
    wr(rtcp_pkg::ADDR_INT_CTRL, 32'h0, 4'h1);
    wr(rtcp_pkg::ADDR_CTRL_A, 32'h1, 4'h1);
    rise(0, t0);
    repeat (3) @(posedge sys_clk);
    chk_bit("ovf_irq", 1'b0, ovf_irq);
    rd_chk(rtcp_pkg::ADDR_INT_FLAGS, 32'h1, 32'h1);
    wr(rtcp_pkg::ADDR_CTRL_A, 32'h0, 4'h1);
    bus(1'b0, rtcp_pkg::ADDR_COUNT, 32'h0, 4'hf, q);
    repeat (2000) @(posedge sys_clk);
    rd_chk(rtcp_pkg::ADDR_COUNT, q, 32'hffff);
    // slow-down correction holds every second step: at div 1 a tick every 4 edges
    wr(rtcp_pkg::ADDR_CLK_SEL, 32'h2, 4'h1);
    wr(rtcp_pkg::ADDR_CALIB, 32'ha0, 4'h1);
    wr(rtcp_pkg::ADDR_CTRL_A, (32'h1 << rtcp_pkg::CTRL_CORR_BIT) |
       (32'h1 << rtcp_pkg::CTRL_DIV_LSB) | 32'h1, 4'h1);
    rise(0, t0);
    rise(0, t1);
    chk_word("corrected period", 32'(4 * 4 * 14), 32'(t1 - t0));
    wr(rtcp_pkg::ADDR_CTRL_A, 32'h0, 4'h1);
    // periodic timer alone, counter left disabled
    wr(rtcp_pkg::ADDR_CLK_SEL, 32'h0, 4'h1);
    wr(rtcp_pkg::ADDR_PIT_INT_CTRL, 32'h1, 4'h1);
    for (int c = 1; c <= 3; c += 2) begin
      wr(rtcp_pkg::ADDR_PIT_CTRL, 32'(c) << rtcp_pkg::PIT_PER_LSB, 4'h1);
      wr(rtcp_pkg::ADDR_PIT_CTRL, (32'(c) << rtcp_pkg::PIT_PER_LSB) | 32'h1, 4'h1);
      rise(2, t0);
      rise(2, t1);
      chk_word("wave period", 32'((2 << c) * 20), 32'(t1 - t0));
      chk_bit("pit_irq", 1'b1, pit_irq);
      if (c == 3) begin
        rise(3, t0);
        rise(3, t1);
        chk_word("event period", 32'(64 * 20), 32'(t1 - t0));
      end
      wr(rtcp_pkg::ADDR_PIT_CTRL, 32'h0, 4'h1);
      wr(rtcp_pkg::ADDR_PIT_INT_FLAGS, 32'h1, 4'h1);
      repeat (60) @(posedge sys_clk);
      chk_bit("pit_wave", 1'b0, pit_wave);
      chk_word("pit_event", 32'h0, {24'h0, pit_event});
      chk_bit("pit_irq", 1'b0, pit_irq);
    end
    end_of_test;
  end
endmodule
